// ---- logic/aor_pkg.sv ----
package aor_pkg;

    // --------------------
    // sizes
    // --------------------
    localparam int CHANNELS = 4;
    localparam int VALUE_W  = 16;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int CFG_W    = 8;
    localparam int DUR_W    = 3;
    localparam int MS_W     = 14;
    localparam int CYC_W    = 16;
    localparam int IRQ_W    = 2 * CHANNELS + 1;

    // --------------------
    // register map (byte addresses)
    // --------------------
    localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR  = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DIAG       = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CH_BASE    = 8'h40;
    localparam int                CH_SHIFT       = 5;
    localparam int                CH_SEL_W       = 2;
    localparam logic [4:0]        CH_CMD         = 5'h00;
    localparam logic [4:0]        CH_CFG         = 5'h04;
    localparam logic [4:0]        CH_PROG        = 5'h08;
    localparam logic [4:0]        CH_FAULT       = 5'h0C;
    localparam logic [4:0]        CH_FINAL       = 5'h10;
    localparam logic [4:0]        CH_RATE        = 5'h14;
    localparam logic [4:0]        CH_ECHO        = 5'h18;

    // --------------------
    // fields and reset values
    // --------------------
    localparam int CTRL_RUN_BIT    = 0;
    localparam int CTRL_DUR_LSB    = 1;
    localparam int CFG_CURRENT_BIT = 0;
    localparam int CFG_RAMP_RUN    = 1;
    localparam int CFG_RAMP_PROG   = 2;
    localparam int CFG_RAMP_FAULT  = 3;
    localparam int CFG_OPEN_EN     = 4;
    localparam int CFG_RANGE_4_20  = 5;
    localparam int IRQ_OPEN_LSB    = 0;
    localparam int IRQ_OVER_LSB    = CHANNELS;
    localparam int IRQ_THERM_BIT   = 2 * CHANNELS;

    localparam logic [CFG_W-1:0]   CFG_RESET  = 8'h00;
    localparam logic [VALUE_W-1:0] VAL_RESET  = 16'h0000;
    localparam logic [VALUE_W-1:0] PER_RESET  = 16'h000A;
    localparam logic [DUR_W-1:0]   DUR_RESET  = 3'h0;

    // load current in microamps
    localparam logic [VALUE_W-1:0] MIN_0_20_UA = 16'h0000;
    localparam logic [VALUE_W-1:0] MIN_4_20_UA = 16'h0FA0;

    // --------------------
    // timing
    // --------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_SEC  = 1000000000 / TICK_PERIOD_NS;
    localparam logic [MS_W-1:0] FLASH_HALF_MS = 14'h00FA;
    localparam logic [MS_W-1:0] DUR_1S_MS     = 14'h03E8;
    localparam logic [MS_W-1:0] DUR_2S_MS     = 14'h07D0;
    localparam logic [MS_W-1:0] DUR_5S_MS     = 14'h1388;
    localparam logic [MS_W-1:0] DUR_10S_MS    = 14'h2710;

    // --------------------
    // types
    // --------------------
    typedef enum logic [1:0] {
        PH_NORMAL = 2'b00,
        PH_FAULT  = 2'b01,
        PH_FINAL  = 2'b11
    } aor_phase_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wr;
        logic              rd;
    } aor_bus_type;

    typedef struct packed {
        logic [CHANNELS-1:0][VALUE_W-1:0] loadCurrent;
        logic [CHANNELS-1:0]              shortDetect;
        logic                             overTemp;
        logic                             commFault;
    } aor_sense_type;

    typedef struct packed {
        logic                             valid;
        logic [CHANNELS-1:0][VALUE_W-1:0] echo;
        logic [CHANNELS-1:0]              openLoadFlag;
        logic [CHANNELS-1:0]              overcurrentFlag;
        logic [CHANNELS-1:0]              thermalLimitFlag;
    } aor_report_type;

    // fault state duration in ms, zero means forever
    function automatic logic [MS_W-1:0] faultDurMs(input logic [DUR_W-1:0] code);
        logic [MS_W-1:0] ms;
        ms = '0;
        unique case (code)
            3'h1:    ms = DUR_1S_MS;
            3'h2:    ms = DUR_2S_MS;
            3'h3:    ms = DUR_5S_MS;
            3'h4:    ms = DUR_10S_MS;
            default: ms = '0;
        endcase
        return ms;
    endfunction

endpackage

// ---- logic/aor_channel_ramp.sv ----
module aor_channel_ramp
    import aor_pkg::*;
(
    input  wire logic [aor_pkg::VALUE_W-1:0] present,
    input  wire logic [aor_pkg::VALUE_W-1:0] target,
    input  wire logic [aor_pkg::VALUE_W-1:0] unitsPerSecond,
    output logic      [aor_pkg::VALUE_W-1:0] nextValue
);
    import aor_pkg::*;

    logic [VALUE_W-1:0] step;
    logic [VALUE_W:0]   gap;
    logic               up;

    always_comb begin
        // step per tick is rate times tick period, at least one unit
        step = VALUE_W'(unitsPerSecond / VALUE_W'(TICKS_PER_SEC));
        if (step == '0) begin
            step = 16'h0001;
        end
        up  = $signed(target) > $signed(present);
        gap = up ? ((VALUE_W+1)'($signed(target)) - (VALUE_W+1)'($signed(present)))
                 : ((VALUE_W+1)'($signed(present)) - (VALUE_W+1)'($signed(target)));
        if (gap <= {1'b0, step}) begin
            nextValue = target;
        end else if (up) begin
            nextValue = present + step;
        end else begin
            nextValue = present - step;
        end
    end
endmodule

// ---- logic/aor_output_diag.sv ----
// Notes on behaviour
// - run mode ramping limits output change rate
// - program value approached at ramp rate
// - fault value approached at ramp rate
// - ramp rate is units per second
// - echo applied value and status each period
// - open load only on current channels
// - open load when current below range minimum
// - open load check disabled after reset
// - open load sets flag, flashes red
// - cleared open load restores steady yellow
// - short protection only on voltage channels
// - short faults channel, limits current, flashes red
// - short removed restarts commanded, steady yellow
// - over temperature holds thermal flag
// - final fault value after duration, ramped
module aor_output_diag
    import aor_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input  wire logic                             core_clk,
    input  wire logic                             rst_b,
    input  wire aor_pkg::aor_bus_type             bus,
    output logic      [aor_pkg::DATA_W-1:0]       rdData,
    input  wire aor_pkg::aor_sense_type           sense,
    output logic      [aor_pkg::CHANNELS-1:0][aor_pkg::VALUE_W-1:0] dacValue,
    output logic      [aor_pkg::CHANNELS-1:0]     dacEnable,
    output logic      [aor_pkg::CHANNELS-1:0]     currentLimit,
    output logic      [aor_pkg::CHANNELS-1:0]     ledRed,
    output logic      [aor_pkg::CHANNELS-1:0]     ledYellow,
    output aor_pkg::aor_report_type               report,
    output logic                                  irq
);
    import aor_pkg::*;

    // --------------------
    // state
    // --------------------
    typedef struct packed {
        logic                             runMode;
        logic [DUR_W-1:0]                 faultDur;
        logic [VALUE_W-1:0]               period;
        logic [CHANNELS-1:0][VALUE_W-1:0] cmd;
        logic [CHANNELS-1:0][VALUE_W-1:0] progVal;
        logic [CHANNELS-1:0][VALUE_W-1:0] faultVal;
        logic [CHANNELS-1:0][VALUE_W-1:0] finalVal;
        logic [CHANNELS-1:0][VALUE_W-1:0] rate;
        logic [CHANNELS-1:0][VALUE_W-1:0] applied;
        logic [CHANNELS-1:0][CFG_W-1:0]   cfg;
        aor_phase_type                    phase;
        logic [MS_W-1:0]                  faultMs;
        logic [CYC_W-1:0]                 tickCnt;
        logic [MS_W-1:0]                  flashCnt;
        logic                             flash;
        logic [VALUE_W-1:0]               periodCnt;
        logic [CHANNELS-1:0]              openLoadFlag;
        logic [CHANNELS-1:0]              overcurrentFlag;
        logic [CHANNELS-1:0]              thermalLimitFlag;
        logic [IRQ_W-1:0]                 irqStatus;
        logic [IRQ_W-1:0]                 irqEnable;
        logic [DATA_W-1:0]                rdData;
        logic [CHANNELS-1:0]              dacEnable;
        logic [CHANNELS-1:0]              currentLimit;
        logic [CHANNELS-1:0]              ledRed;
        logic [CHANNELS-1:0]              ledYellow;
        aor_report_type                   report;
        logic                             irq;
    } aor_state_type;

    aor_state_type state;
    aor_state_type next_state;

    logic [CHANNELS-1:0][VALUE_W-1:0] target;
    logic [CHANNELS-1:0][VALUE_W-1:0] rampValue;
    logic [CHANNELS-1:0]              rampEnable;

    // --------------------
    // helpers
    // --------------------
    function automatic logic isChannelReg(input logic [ADDR_W-1:0] a);
        return a >= REG_CH_BASE;
    endfunction

    function automatic logic [CH_SEL_W-1:0] chanOf(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] rel;
        rel = a - REG_CH_BASE;
        return rel[CH_SHIFT +: CH_SEL_W];
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [VALUE_W-1:0] v);
        return {{(DATA_W-VALUE_W){1'b0}}, v};
    endfunction

    // --------------------
    // target selection and ramp
    // --------------------
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            unique case (state.phase)
                PH_NORMAL: begin
                    target[c]     = state.runMode ? state.cmd[c] : state.progVal[c];
                    rampEnable[c] = state.runMode ? state.cfg[c][CFG_RAMP_RUN]
                                                  : state.cfg[c][CFG_RAMP_PROG];
                end
                PH_FAULT: begin
                    target[c]     = state.faultVal[c];
                    rampEnable[c] = state.cfg[c][CFG_RAMP_FAULT];
                end
                default: begin
                    target[c]     = state.finalVal[c];
                    rampEnable[c] = state.cfg[c][CFG_RAMP_FAULT];
                end
            endcase
        end
    end

    for (genvar g = 0; g < CHANNELS; g++) begin : gen_ramp
        aor_channel_ramp u_ramp (
            .present        (state.applied[g]),
            .target         (target[g]),
            .unitsPerSecond (state.rate[g]),
            .nextValue      (rampValue[g])
        );
    end

    // --------------------
    // next state
    // --------------------
    always_comb begin
        logic                tick;
        logic                periodDone;
        logic [MS_W-1:0]     durMs;
        logic [CHANNELS-1:0] openNow;
        logic [CHANNELS-1:0] shortNow;
        logic [VALUE_W-1:0]  minUa;
        logic [CH_SEL_W-1:0] ch;
        logic [4:0]          off;

        next_state = state;
        tick       = state.tickCnt == CYC_W'(TICK_CYCLES_P - 1);
        durMs      = faultDurMs(state.faultDur);
        ch         = chanOf(bus.addr);
        off        = bus.addr[4:0];
        openNow    = '0;
        shortNow   = '0;
        minUa      = '0;
        periodDone = 1'b0;

        // 1 ms tick and indicator flash
        next_state.tickCnt = tick ? '0 : state.tickCnt + 1'b1;
        if (tick) begin
            if (state.flashCnt == FLASH_HALF_MS - 1'b1) begin
                next_state.flashCnt = '0;
                next_state.flash    = ~state.flash;
            end else begin
                next_state.flashCnt = state.flashCnt + 1'b1;
            end
        end

        // connection fault sequencing
        unique case (state.phase)
            PH_NORMAL: begin
                next_state.faultMs = '0;
                if (sense.commFault) begin
                    next_state.phase = PH_FAULT;
                end
            end
            PH_FAULT: begin
                if (!sense.commFault) begin
                    next_state.phase = PH_NORMAL;
                end else if (tick && durMs != '0) begin
                    next_state.faultMs = state.faultMs + 1'b1;
                    if (state.faultMs == durMs - 1'b1) begin
                        next_state.phase = PH_FINAL;
                    end
                end
            end
            default: begin
                if (!sense.commFault) begin
                    next_state.phase = PH_NORMAL;
                end
            end
        endcase

        // per channel output and diagnostics
        for (int c = 0; c < CHANNELS; c++) begin
            if (!rampEnable[c]) begin
                next_state.applied[c] = target[c];
            end else if (tick) begin
                next_state.applied[c] = rampValue[c];
            end
            minUa = state.cfg[c][CFG_RANGE_4_20] ? MIN_4_20_UA : MIN_0_20_UA;
            openNow[c] = state.cfg[c][CFG_CURRENT_BIT] && state.cfg[c][CFG_OPEN_EN]
                         && (sense.loadCurrent[c] < minUa);
            shortNow[c] = !state.cfg[c][CFG_CURRENT_BIT] && sense.shortDetect[c];
            next_state.openLoadFlag[c]     = openNow[c];
            next_state.overcurrentFlag[c]  = shortNow[c];
            next_state.thermalLimitFlag[c] = sense.overTemp;
            // short faults the drive; removal restarts at the commanded value
            next_state.dacEnable[c]    = !shortNow[c];
            next_state.currentLimit[c] = shortNow[c];
            next_state.ledRed[c]       = (openNow[c] || shortNow[c]) && state.flash;
            next_state.ledYellow[c]    = !(openNow[c] || shortNow[c]);
        end

        // --------------------
        // register bus
        // --------------------
        next_state.rdData = '0;
        if (bus.wr) begin
            if (isChannelReg(bus.addr)) begin
                unique case (off)
                    CH_CMD:   next_state.cmd[ch]      = bus.wrData[VALUE_W-1:0];
                    CH_CFG:   next_state.cfg[ch]      = bus.wrData[CFG_W-1:0];
                    CH_PROG:  next_state.progVal[ch]  = bus.wrData[VALUE_W-1:0];
                    CH_FAULT: next_state.faultVal[ch] = bus.wrData[VALUE_W-1:0];
                    CH_FINAL: next_state.finalVal[ch] = bus.wrData[VALUE_W-1:0];
                    CH_RATE:  next_state.rate[ch]     = bus.wrData[VALUE_W-1:0];
                    default:  ;
                endcase
            end else begin
                unique case (bus.addr)
                    REG_CTRL: begin
                        next_state.runMode  = bus.wrData[CTRL_RUN_BIT];
                        next_state.faultDur = bus.wrData[CTRL_DUR_LSB +: DUR_W];
                    end
                    REG_PERIOD:     next_state.period    = bus.wrData[VALUE_W-1:0];
                    REG_IRQ_ENABLE: next_state.irqEnable = bus.wrData[IRQ_W-1:0];
                    REG_IRQ_CLEAR:  next_state.irqStatus = state.irqStatus
                                                           & ~bus.wrData[IRQ_W-1:0];
                    default:        ;
                endcase
            end
        end
        if (bus.rd) begin
            if (isChannelReg(bus.addr)) begin
                unique case (off)
                    CH_CMD:   next_state.rdData = widen(state.cmd[ch]);
                    CH_CFG:   next_state.rdData = {{(DATA_W-CFG_W){1'b0}}, state.cfg[ch]};
                    CH_PROG:  next_state.rdData = widen(state.progVal[ch]);
                    CH_FAULT: next_state.rdData = widen(state.faultVal[ch]);
                    CH_FINAL: next_state.rdData = widen(state.finalVal[ch]);
                    CH_RATE:  next_state.rdData = widen(state.rate[ch]);
                    CH_ECHO:  next_state.rdData = widen(state.applied[ch]);
                    default:  next_state.rdData = '0;
                endcase
            end else begin
                unique case (bus.addr)
                    REG_CTRL: next_state.rdData = DATA_W'({state.faultDur, state.runMode});
                    REG_PERIOD: next_state.rdData = widen(state.period);
                    REG_IRQ_STATUS: next_state.rdData = DATA_W'(state.irqStatus);
                    REG_IRQ_ENABLE: next_state.rdData = DATA_W'(state.irqEnable);
                    REG_DIAG: next_state.rdData = DATA_W'({state.phase,
                                                           state.thermalLimitFlag,
                                                           state.overcurrentFlag,
                                                           state.openLoadFlag});
                    default:  next_state.rdData = '0;
                endcase
            end
        end

        // --------------------
        // interrupts: a new condition wins over a clear in the same cycle
        // --------------------
        next_state.irqStatus[IRQ_OPEN_LSB +: CHANNELS] =
            next_state.irqStatus[IRQ_OPEN_LSB +: CHANNELS] | (openNow & ~state.openLoadFlag);
        next_state.irqStatus[IRQ_OVER_LSB +: CHANNELS] =
            next_state.irqStatus[IRQ_OVER_LSB +: CHANNELS]
            | (shortNow & ~state.overcurrentFlag);
        next_state.irqStatus[IRQ_THERM_BIT] =
            next_state.irqStatus[IRQ_THERM_BIT] | (sense.overTemp & ~state.thermalLimitFlag[0]);
        next_state.irq = |(next_state.irqStatus & next_state.irqEnable);

        // --------------------
        // echo and status report once per update period
        // --------------------
        next_state.report.valid = 1'b0;
        if (tick) begin
            if (state.periodCnt + 1'b1 >= state.period) begin
                next_state.periodCnt = '0;
                periodDone           = 1'b1;
            end else begin
                next_state.periodCnt = state.periodCnt + 1'b1;
            end
        end
        if (periodDone) begin
            next_state.report.valid            = 1'b1;
            next_state.report.echo             = state.applied;
            next_state.report.openLoadFlag     = state.openLoadFlag;
            next_state.report.overcurrentFlag  = state.overcurrentFlag;
            next_state.report.thermalLimitFlag = state.thermalLimitFlag;
        end
    end

    // --------------------
    // registers
    // --------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state           <= '0;
            state.cfg       <= {CHANNELS{CFG_RESET}};
            state.period    <= PER_RESET;
            state.faultDur  <= DUR_RESET;
            state.phase     <= PH_NORMAL;
            state.dacEnable <= '1;
            state.ledYellow <= '1;
        end else begin
            state <= next_state;
        end
    end

    assign rdData       = state.rdData;
    assign dacValue     = state.applied;
    assign dacEnable    = state.dacEnable;
    assign currentLimit = state.currentLimit;
    assign ledRed       = state.ledRed;
    assign ledYellow    = state.ledYellow;
    assign report       = state.report;
    assign irq          = state.irq;
endmodule

// ---- bench/aor_output_diag_sva.sv ----
module aor_output_diag_sva
    import aor_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic                        core_clk,
    input wire logic                        rst_b,
    input wire aor_pkg::aor_bus_type        bus,
    input wire logic [aor_pkg::DATA_W-1:0]  rdData,
    input wire aor_pkg::aor_sense_type      sense,
    input wire logic [aor_pkg::CHANNELS-1:0][aor_pkg::VALUE_W-1:0] dacValue,
    input wire logic [aor_pkg::CHANNELS-1:0] dacEnable,
    input wire logic [aor_pkg::CHANNELS-1:0] currentLimit,
    input wire logic [aor_pkg::CHANNELS-1:0] ledRed,
    input wire logic [aor_pkg::CHANNELS-1:0] ledYellow,
    input wire aor_pkg::aor_report_type     report,
    input wire logic                        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_lim; (currentLimit & dacEnable) == '0; endproperty
    a_lim:
    assert property (p_lim) else $error("drive on while limited");
    property p_src; currentLimit != '0 |-> (currentLimit & ~$past(sense.shortDetect)) == '0;
    endproperty
    a_src:
    assert property (p_src) else $error("limit without short");
    property p_led; (ledRed & ledYellow) == '0; endproperty
    a_led:
    assert property (p_led) else $error("red and yellow together");
    property p_back; $fell(|currentLimit) |-> dacEnable == '1; endproperty
    a_back:
    assert property (p_back) else $error("no restart after short");
    property p_pulse; report.valid |=> !report.valid [*8]; endproperty
    a_pulse:
    assert property (p_pulse) else $error("report too often");
    property p_hot; sense.overTemp [*4] ##1 report.valid |-> report.thermalLimitFlag == '1;
    endproperty
    a_hot:
    assert property (p_hot) else $error("thermal flag missing");
    property p_cool; !sense.overTemp [*4] ##1 report.valid |-> report.thermalLimitFlag == '0;
    endproperty
    a_cool:
    assert property (p_cool) else $error("thermal flag stuck");
    property p_rd; rdData != '0 |-> $past(bus.rd); endproperty
    a_rd:
    assert property (p_rd) else $error("read data without read");
endmodule

bind aor_output_diag aor_output_diag_sva #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_sva (
    .core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdData(rdData), .sense(sense),
    .dacValue(dacValue), .dacEnable(dacEnable), .currentLimit(currentLimit),
    .ledRed(ledRed), .ledYellow(ledYellow), .report(report), .irq(irq)
);

// ---- bench/aor_field_model.sv ----
module aor_field_model
    import aor_pkg::*;
(
    input  wire logic [aor_pkg::CHANNELS-1:0][aor_pkg::VALUE_W-1:0] drawUa,
    input  wire logic [aor_pkg::CHANNELS-1:0] shorted,
    input  wire logic                         hot,
    input  wire logic                         linkDown,
    input  wire logic [aor_pkg::CHANNELS-1:0] dacEnable,
    output aor_pkg::aor_sense_type            sense
);
    timeunit 1ns;
    timeprecision 1ns;
    // a load draws nothing while its drive is switched off
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            sense.loadCurrent[i] = dacEnable[i] ? drawUa[i] : '0;
        end
        sense.shortDetect = shorted;
        sense.overTemp = hot;
        sense.commFault = linkDown;
    end
endmodule

// ---- bench/test_analog_out_ramp_and_diagnostics.sv ----
module test_analog_out_ramp_and_diagnostics;
    timeunit 1ns;
    timeprecision 1ns;
    import aor_pkg::*;
    logic                             core_clk = 1'b0;
    logic                             rst_b = 1'b0;
    aor_bus_type                      bus = '0;
    logic [DATA_W-1:0]                rdData;
    aor_sense_type                    sense;
    aor_report_type                   report;
    logic [CHANNELS-1:0][VALUE_W-1:0] dacValue;
    logic [CHANNELS-1:0][VALUE_W-1:0] drawUa = '0;
    logic [CHANNELS-1:0]              dacEnable, currentLimit, ledRed, ledYellow;
    logic [CHANNELS-1:0]              shorted = '0;
    logic                             hot = 1'b0, linkDown = 1'b0, irq;
    int                               errors = 0, checked = 0, c, t, s, x, e;

    aor_output_diag #(.TICK_CYCLES_P(20)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdData(rdData), .sense(sense),
        .dacValue(dacValue), .dacEnable(dacEnable), .currentLimit(currentLimit),
        .ledRed(ledRed), .ledYellow(ledYellow), .report(report), .irq(irq)
    );
    aor_field_model i_field (
        .drawUa(drawUa), .shorted(shorted), .hot(hot), .linkDown(linkDown),
        .dacEnable(dacEnable), .sense(sense)
    );

    initial forever #50 core_clk = ~core_clk;

    function automatic logic [7:0] ca(input int ch, input logic [4:0] off);
        return REG_CH_BASE + 8'(ch * 32) + 8'(off);
    endfunction
    function automatic logic [15:0] nxt(input logic [15:0] p, input logic [15:0] g, input int st);
        if (p < g) return (int'(g - p) > st) ? p + 16'(st) : g;
        return (int'(p - g) > st) ? p - 16'(st) : g;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus <= '{addr: a, wrData: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 cmp(rdData, exp);
    endtask
    task automatic st();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic rep();
        repeat (2) begin
            x = 0;
            do begin
                @(posedge core_clk);
                #1 x++;
            end while (report.valid !== 1'b1 && x < 100);
            cmp(32'(report.valid), 32'h1);
        end
    endtask
    // every change of the output must be one clamped step toward the goal
    task automatic ramp(input int ch, input logic [15:0] g, input int st);
        logic [15:0] p;
        int          n;
        p = dacValue[ch];
        n = 0;
        while (dacValue[ch] !== g && n < 30000) begin
            @(posedge core_clk);
            #1 n++;
            if (dacValue[ch] !== p) begin
                cmp(32'(dacValue[ch]), 32'(nxt(p, g, st)));
                p = dacValue[ch];
            end
        end
        cmp(32'(dacValue[ch]), 32'(g));
    endtask
    task automatic wrap_up();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(50385));
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        c = $urandom % CHANNELS;
        rd(ca(c, CH_CFG), 32'(CFG_RESET));
        rd(REG_PERIOD, 32'(PER_RESET));
        rd(8'hFC, 32'h0);
        wr(REG_PERIOD, 32'h1);
        wr(REG_IRQ_ENABLE, 32'h1FF);
        s = $urandom_range(5000, 500);
        wr(ca(c, CH_RATE), 32'(s));
        s = (s < 1000) ? 1 : s / 1000;
        wr(ca(c, CH_CFG), 32'h2);
        wr(REG_CTRL, 32'h1);
        t = $urandom % 300;
        wr(ca(c, CH_CMD), 32'(t));
        ramp(c, 16'(t), s);
        rd(ca(c, CH_ECHO), 32'(t));
        rep();
        cmp(32'(report.echo[c]), 32'(t));
        wr(ca(c, CH_CFG), 32'h0);
        t = $urandom % 300;
        wr(ca(c, CH_CMD), 32'(t));
        ramp(c, 16'(t), 65535);
        wr(ca(c, CH_CFG), 32'h4);
        t = $urandom % 300;
        wr(ca(c, CH_PROG), 32'(t));
        wr(REG_CTRL, 32'h0);
        ramp(c, 16'(t), s);
        t = $urandom % 300;
        wr(ca(c, CH_FAULT), 32'(t));
        wr(ca(c, CH_FINAL), 32'(t + 100));
        wr(ca(c, CH_CFG), 32'h8);
        wr(REG_CTRL, 32'h2);
        linkDown <= 1'b1;
        ramp(c, 16'(t), s);
        ramp(c, 16'(t + 100), s);
        linkDown <= 1'b0;
        wr(ca(c, CH_CFG), 32'h1);
        shorted[c] <= 1'b1;
        st();
        cmp(32'({currentLimit[c], dacEnable[c], irq}), 32'h2);
        wr(ca(c, CH_CFG), 32'h0);
        st();
        cmp(32'({currentLimit[c], dacEnable[c], irq}), 32'h5);
        rep();
        cmp(32'(report.overcurrentFlag[c]), 32'h1);
        wr(REG_IRQ_ENABLE, 32'h0);
        st();
        cmp(32'(irq), 32'h0);
        wr(REG_IRQ_ENABLE, 32'h1FF);
        shorted[c] <= 1'b0;
        st();
        cmp(32'({ledYellow[c], dacEnable[c], currentLimit[c]}), 32'h6);
        wr(REG_IRQ_CLEAR, 32'h1FF);
        st();
        cmp(32'(irq), 32'h0);
        for (int i = 0; i < 8; i++) begin
            s = (32'h11302131 >> 8 * (i % 4)) & 'hFF;
            t = (i == 0) ? 3999 : (i == 4) ? 4000 : $urandom % 8000;
            wr(ca(c, CH_CFG), 32'(s));
            drawUa[c] <= 16'(t);
            rep();
            e = (s == 'h31 && t < 4000);
            cmp(32'(ledRed[c] & !e), 32'h0);
            cmp(32'({report.openLoadFlag[c], ledYellow[c]}), e ? 32'h2 : 32'h1);
        end
        hot <= 1'b1;
        rep();
        cmp(32'(report.thermalLimitFlag), 32'({CHANNELS{1'b1}}));
        hot <= 1'b0;
        rep();
        cmp(32'(report.thermalLimitFlag), 32'h0);
        wrap_up();
    end
endmodule
